// File: rtl/out_route_pkg.sv
// constants for the output driver routing register bank
// assumes one 125 MHz system clock and a byte-wide register access port
package out_route_pkg;

    // register offsets on page 0
    localparam logic [7:0] ADDR_RHP_DAC_ROUTE  = 8'h40;
    localparam logic [7:0] ADDR_RCOM_DAC_ROUTE = 8'h47;
    localparam logic [7:0] ADDR_RCOM_LEVEL     = 8'h48;
    localparam logic [7:0] ADDR_RSVD_A_FIRST   = 8'h49;
    localparam logic [7:0] ADDR_RSVD_A_LAST    = 8'h4E;
    localparam logic [7:0] ADDR_RSVD_B         = 8'h4F;
    localparam logic [7:0] ADDR_RSVD_C         = 8'h50;
    localparam logic [7:0] ADDR_LL_LSTAGE      = 8'h51;
    localparam logic [7:0] ADDR_LL_LDAC        = 8'h52;
    localparam logic [7:0] ADDR_RSVD_D         = 8'h53;
    localparam logic [7:0] ADDR_LL_RSTAGE      = 8'h54;
    localparam logic [7:0] ADDR_LL_RDAC        = 8'h55;
    localparam logic [7:0] ADDR_LL_LEVEL       = 8'h56;
    localparam logic [7:0] ADDR_RSVD_E         = 8'h57;

    // routing registers, by index
    localparam int         SRC_COUNT     = 6;
    localparam int         SRC_RHP       = 0;
    localparam int         SRC_RCOM      = 1;
    localparam int         SRC_LL_FIRST  = 2;
    localparam logic [7:0] SRC_ADDR [SRC_COUNT] = '{ADDR_RHP_DAC_ROUTE, ADDR_RCOM_DAC_ROUTE,
        ADDR_LL_LSTAGE, ADDR_LL_LDAC, ADDR_LL_RSTAGE, ADDR_LL_RDAC};

    // field positions
    localparam int ROUTE_EN_BIT = 7;
    localparam int VOL_MSB      = 6;
    localparam int LEVEL_MSB    = 7;
    localparam int LEVEL_LSB    = 4;
    localparam int UNMUTE_BIT   = 3;
    localparam int PDHIZ_BIT    = 2;
    localparam int PEND_BIT     = 1;
    localparam int PWR_BIT      = 0;

    // reset values and fixed read values
    localparam logic [7:0] ROUTE_RESET   = 8'h00;
    localparam logic [3:0] LEVEL_RESET   = 4'h0;
    localparam logic [3:0] LEVEL_MAX     = 4'h9;
    localparam logic       UNMUTE_RESET  = 1'b0;
    localparam logic       PDHIZ_RESET   = 1'b1;
    localparam logic       PEND_RESET    = 1'b1;
    localparam logic       PWR_RESET     = 1'b0;
    localparam logic [7:0] RSVD_ZERO     = 8'h00;
    localparam logic [7:0] RSVD_B_VALUE  = 8'h02;

    // gain settling time
    localparam int         SYS_CLK_MHZ    = 125;
    localparam int         GAIN_SETTLE_NS = 1000;
    localparam logic [7:0] SETTLE_CYCLES  =
        8'((GAIN_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000);

endpackage

// File: rtl/gain_if.sv
// carrier between the register bank and its gain settling trackers
// assumes both ends run on the same system clock
`timescale 1ns/100ps
`default_nettype none
interface gain_if;
    logic [31:0] target;
    logic        pending;

    modport ctrl    (output target, input pending);
    modport tracker (input target, output pending);
endinterface // gain_if
`default_nettype wire

// File: rtl/gain_settle_tracker.sv
// tracks whether the programmed gains of one driver have been applied
// assumes the target word changes only on register writes, same clock
`timescale 1ns/100ps
`default_nettype none
module gain_settle_tracker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // gain target and status
    gain_if.tracker  g
);

    logic [31:0] prev_target;
    logic [7:0]  settle_cnt;
    logic [7:0]  next_cnt;
    wire         changed;

    assign changed  = g.target != prev_target;
    // any change restarts the whole settle time
    assign next_cnt = changed ? out_route_pkg::SETTLE_CYCLES :
                      (settle_cnt != 8'h00) ? settle_cnt - 8'h01 : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_target <= 32'h0000_0000;
            settle_cnt  <= out_route_pkg::SETTLE_CYCLES;
            g.pending   <= out_route_pkg::PEND_RESET;
        end else begin
            prev_target <= g.target;
            settle_cnt  <= next_cnt;
            g.pending   <= next_cnt != 8'h00;
        end
    end

    // helper: cycles since last change or reset
    logic [7:0] quiet_cnt;
    always_ff @(posedge sys_clk) begin
        if (srst || changed) begin
            quiet_cnt <= 8'h00;
        end else if (quiet_cnt != 8'hFF) begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end

    chk_pending_rise: assert property (@(posedge sys_clk) disable iff (srst)
        changed |=> g.pending [*8])
        else $error("pending did not hold after a gain change");

    chk_pending_clear: assert property (@(posedge sys_clk) disable iff (srst)
        (quiet_cnt > out_route_pkg::SETTLE_CYCLES) |-> !g.pending)
        else $error("pending still set after the settle time");

endmodule // gain_settle_tracker
`default_nettype wire

// File: rtl/output_driver_routing_regs.sv
// register bank for the right common headphone and left line output drivers
// assumes an upstream control-bus engine giving byte register accesses on sys_clk
`timescale 1ns/100ps
`default_nettype none
module output_driver_routing_regs (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // register access port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    output logic                  reg_rvalid,
    // analog power status pin of the left line output
    input  wire logic             left_line_out_powered_pin,
    // right headphone output, right converter path source
    output logic                  right_headphone_out_src_en,
    output logic      [6:0]       right_headphone_out_vol,
    // right common headphone output
    output logic                  right_common_headphone_out_src_en,
    output logic      [6:0]       right_common_headphone_out_vol,
    output logic      [3:0]       right_common_headphone_out_level,
    output logic                  right_common_headphone_out_unmute,
    output logic                  right_common_headphone_out_pd_hiz,
    output logic                  right_common_headphone_out_power_up,
    // left line output: 0 left stage, 1 left path, 2 right stage, 3 right path
    output logic      [3:0]       left_line_out_src_en,
    output logic      [3:0][6:0]  left_line_out_vol,
    output logic      [3:0]       left_line_out_level,
    output logic                  left_line_out_unmute
);

    // routing registers
    logic [7:0] src_reg [out_route_pkg::SRC_COUNT];
    wire  [7:0] src_rd_acc [out_route_pkg::SRC_COUNT + 1];

    assign src_rd_acc[0] = 8'h00;

    genvar i;
    generate
        for (i = 0; i < out_route_pkg::SRC_COUNT; i++) begin : g_src
            wire wr_hit;
            wire rd_hit;
            assign wr_hit = reg_wr && (reg_addr == out_route_pkg::SRC_ADDR[i]);
            assign rd_hit = reg_addr == out_route_pkg::SRC_ADDR[i];
            assign src_rd_acc[i + 1] = src_rd_acc[i] | (rd_hit ? src_reg[i] : 8'h00);
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    src_reg[i] <= out_route_pkg::ROUTE_RESET;
                end else if (wr_hit) begin
                    src_reg[i] <= reg_wdata;
                end
            end
        end
    endgenerate

    // level control registers
    logic [3:0] rcom_level;
    logic       rcom_unmute;
    logic       rcom_pd_hiz;
    logic       rcom_power;
    logic [3:0] ll_level;
    logic       ll_unmute;
    logic [7:0] rsvd_d;
    logic [7:0] rsvd_e;

    wire wr_rcom_level;
    wire wr_ll_level;
    wire wr_rsvd_d;
    wire wr_rsvd_e;

    assign wr_rcom_level = reg_wr && (reg_addr == out_route_pkg::ADDR_RCOM_LEVEL);
    assign wr_ll_level   = reg_wr && (reg_addr == out_route_pkg::ADDR_LL_LEVEL);
    assign wr_rsvd_d     = reg_wr && (reg_addr == out_route_pkg::ADDR_RSVD_D);
    assign wr_rsvd_e     = reg_wr && (reg_addr == out_route_pkg::ADDR_RSVD_E);

    // pending bit is not stored here, so writes to bit 1 cannot reach it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rcom_level  <= out_route_pkg::LEVEL_RESET;
            rcom_unmute <= out_route_pkg::UNMUTE_RESET;
            rcom_pd_hiz <= out_route_pkg::PDHIZ_RESET;
            rcom_power  <= out_route_pkg::PWR_RESET;
        end else if (wr_rcom_level) begin
            rcom_level  <= reg_wdata[out_route_pkg::LEVEL_MSB:out_route_pkg::LEVEL_LSB];
            rcom_unmute <= reg_wdata[out_route_pkg::UNMUTE_BIT];
            rcom_pd_hiz <= reg_wdata[out_route_pkg::PDHIZ_BIT];
            rcom_power  <= reg_wdata[out_route_pkg::PWR_BIT];
        end
    end

    // only level and mute are writable; bits 2..0 are read-only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ll_level  <= out_route_pkg::LEVEL_RESET;
            ll_unmute <= out_route_pkg::UNMUTE_RESET;
        end else if (wr_ll_level) begin
            ll_level  <= reg_wdata[out_route_pkg::LEVEL_MSB:out_route_pkg::LEVEL_LSB];
            ll_unmute <= reg_wdata[out_route_pkg::UNMUTE_BIT];
        end
    end

    // writable reserved locations; stored only so readback is stable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsvd_d <= out_route_pkg::RSVD_ZERO;
            rsvd_e <= out_route_pkg::RSVD_ZERO;
        end else begin
            if (wr_rsvd_d) begin
                rsvd_d <= reg_wdata;
            end
            if (wr_rsvd_e) begin
                rsvd_e <= reg_wdata;
            end
        end
    end

    // power status pin crosses in from the analog side
    logic pwr_meta;
    logic pwr_sync;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwr_meta <= 1'b0;
            pwr_sync <= out_route_pkg::PWR_RESET;
        end else begin
            pwr_meta <= left_line_out_powered_pin;
            pwr_sync <= pwr_meta;
        end
    end

    // gain settle tracking for the right common headphone and left line drivers
    gain_if rcom_gain ();
    gain_if ll_gain ();

    assign rcom_gain.target = {21'h00_0000, src_reg[out_route_pkg::SRC_RCOM][6:0], rcom_level};
    assign ll_gain.target   = {src_reg[2][6:0], src_reg[3][6:0], src_reg[4][6:0],
                               src_reg[5][6:0], ll_level};

    gain_settle_tracker u_rcom_tracker (
        .sys_clk (sys_clk),
        .srst    (srst),
        .g       (rcom_gain)
    );

    gain_settle_tracker u_ll_tracker (
        .sys_clk (sys_clk),
        .srst    (srst),
        .g       (ll_gain)
    );

    // read decode
    wire [7:0] rcom_level_word;
    wire [7:0] ll_level_word;
    wire [7:0] read_word;
    wire       rd_rsvd_a;

    assign rcom_level_word = {rcom_level, rcom_unmute, rcom_pd_hiz,
                              rcom_gain.pending, rcom_power};
    assign ll_level_word   = {ll_level, ll_unmute, 1'b0,
                              ll_gain.pending, pwr_sync};
    assign rd_rsvd_a = (reg_addr >= out_route_pkg::ADDR_RSVD_A_FIRST) &&
                       (reg_addr <= out_route_pkg::ADDR_RSVD_A_LAST);
    // reserved read-only spaces read zero except 0x4F, which reads 0x02; writes have no target
    assign read_word = src_rd_acc[out_route_pkg::SRC_COUNT]
        | ((reg_addr == out_route_pkg::ADDR_RCOM_LEVEL) ? rcom_level_word : 8'h00)
        | ((reg_addr == out_route_pkg::ADDR_LL_LEVEL)   ? ll_level_word   : 8'h00)
        | ((reg_addr == out_route_pkg::ADDR_RSVD_B) ? out_route_pkg::RSVD_B_VALUE : 8'h00)
        | ((reg_addr == out_route_pkg::ADDR_RSVD_D)     ? rsvd_d          : 8'h00)
        | ((reg_addr == out_route_pkg::ADDR_RSVD_E)     ? rsvd_e          : 8'h00)
        | (rd_rsvd_a ? out_route_pkg::RSVD_ZERO : 8'h00);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? read_word : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    // levels to the drivers; a forbidden code is held at the top step
    wire [3:0] next_rcom_level_out;
    wire [3:0] next_ll_level_out;
    assign next_rcom_level_out = (rcom_level > out_route_pkg::LEVEL_MAX) ?
                                 out_route_pkg::LEVEL_MAX : rcom_level;
    assign next_ll_level_out   = (ll_level > out_route_pkg::LEVEL_MAX) ?
                                 out_route_pkg::LEVEL_MAX : ll_level;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            right_common_headphone_out_level <= out_route_pkg::LEVEL_RESET;
            left_line_out_level              <= out_route_pkg::LEVEL_RESET;
        end else begin
            right_common_headphone_out_level <= next_rcom_level_out;
            left_line_out_level              <= next_ll_level_out;
        end
    end

    // driver controls straight from the register flops
    assign right_headphone_out_src_en          = src_reg[out_route_pkg::SRC_RHP][7];
    assign right_headphone_out_vol             = src_reg[out_route_pkg::SRC_RHP][6:0];
    assign right_common_headphone_out_src_en   = src_reg[out_route_pkg::SRC_RCOM][7];
    assign right_common_headphone_out_vol      = src_reg[out_route_pkg::SRC_RCOM][6:0];
    assign right_common_headphone_out_unmute   = rcom_unmute;
    assign right_common_headphone_out_pd_hiz   = rcom_pd_hiz;
    assign right_common_headphone_out_power_up = rcom_power;
    assign left_line_out_unmute                = ll_unmute;

    generate
        for (i = 0; i < 4; i++) begin : g_ll_out
            localparam int SRC = out_route_pkg::SRC_LL_FIRST + i;
            assign left_line_out_src_en[i] = src_reg[SRC][7];
            assign left_line_out_vol[i]    = src_reg[SRC][6:0];
        end
    endgenerate

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence rd_at(logic [7:0] a);
        reg_rd && (reg_addr == a);
    endsequence

    sequence wr_at(logic [7:0] a);
        reg_wr && (reg_addr == a);
    endsequence

    chk_route_reset: assert property ($fell(srst) |->
        !right_common_headphone_out_src_en && (right_common_headphone_out_vol == 7'h00)
        && (left_line_out_src_en == 4'h0) && !right_headphone_out_src_en)
        else $error("routing not cleared by reset");

    chk_route_write: assert property (wr_at(out_route_pkg::ADDR_RCOM_DAC_ROUTE) |=>
        (right_common_headphone_out_src_en == $past(reg_wdata[7]))
        && (right_common_headphone_out_vol == $past(reg_wdata[6:0])))
        else $error("right common routing write not applied");

    chk_ll_route_write: assert property (wr_at(out_route_pkg::ADDR_LL_RDAC) |=>
        (left_line_out_src_en[3] == $past(reg_wdata[7]))
        && (left_line_out_vol[3] == $past(reg_wdata[6:0])))
        else $error("left line right path routing write not applied");

    chk_rhp_route_write: assert property (wr_at(out_route_pkg::ADDR_RHP_DAC_ROUTE) |=>
        (right_headphone_out_src_en == $past(reg_wdata[7])))
        else $error("right headphone routing write not applied");

    chk_ll_stage_write: assert property (wr_at(out_route_pkg::ADDR_LL_LSTAGE) |=>
        (left_line_out_src_en[0] == $past(reg_wdata[7]))
        && (left_line_out_vol[0] == $past(reg_wdata[6:0])))
        else $error("left line left stage routing write not applied");

    chk_level_range: assert property ((right_common_headphone_out_level <= 4'h9)
        && (left_line_out_level <= 4'h9))
        else $error("driver level beyond 9 dB");

    // level output is one flop behind the register, hence the extra cycle
    chk_level_follow: assert property (wr_at(out_route_pkg::ADDR_LL_LEVEL)
        ##0 (reg_wdata[7:4] <= 4'h9) |=> ##1
        (left_line_out_level == $past(reg_wdata[7:4], 2)))
        else $error("left line level not applied two cycles after write");

    chk_rcom_level_follow: assert property (wr_at(out_route_pkg::ADDR_RCOM_LEVEL)
        ##0 (reg_wdata[7:4] <= 4'h9) |=> ##1
        (right_common_headphone_out_level == $past(reg_wdata[7:4], 2)))
        else $error("right common level not applied two cycles after write");

    chk_mute_write: assert property (wr_at(out_route_pkg::ADDR_RCOM_LEVEL) |=>
        (right_common_headphone_out_unmute == $past(reg_wdata[3]))
        && (right_common_headphone_out_pd_hiz == $past(reg_wdata[2]))
        && (right_common_headphone_out_power_up == $past(reg_wdata[0])))
        else $error("right common control write not applied");

    chk_pd_reset: assert property ($fell(srst) |-> right_common_headphone_out_pd_hiz
        && !right_common_headphone_out_unmute && !right_common_headphone_out_power_up)
        else $error("right common control reset values wrong");

    chk_pend_reset: assert property ($fell(srst) |-> rcom_gain.pending
        && ll_gain.pending)
        else $error("pending bits not set by reset");

    chk_pend_read: assert property (rd_at(out_route_pkg::ADDR_RCOM_LEVEL) |=>
        reg_rvalid && (reg_rdata[1] == $past(rcom_gain.pending)))
        else $error("right common pending bit misread");

    chk_rsvd_zero: assert property (reg_rd && (rd_rsvd_a
        || (reg_addr == out_route_pkg::ADDR_RSVD_C))
        |=> (reg_rdata == 8'h00))
        else $error("reserved read-only location not zero");

    chk_rsvd_fixed: assert property (rd_at(out_route_pkg::ADDR_RSVD_B) |=>
        reg_rvalid && (reg_rdata == 8'h02))
        else $error("reserved location 79 not reading 0x02");

    chk_rsvd_rw: assert property (wr_at(out_route_pkg::ADDR_RSVD_D)
        ##1 !reg_wr ##1 (rd_at(out_route_pkg::ADDR_RSVD_D) ##0 !reg_wr) |=>
        (reg_rdata == $past(reg_wdata, 3)))
        else $error("writable reserved location lost its value");

    chk_ll_status: assert property (rd_at(out_route_pkg::ADDR_LL_LEVEL) |=>
        (reg_rdata[2] == 1'b0) && (reg_rdata[0] == $past(pwr_sync))
        && (reg_rdata[1] == $past(ll_gain.pending)))
        else $error("left line status bits misread");

    chk_ll_mute: assert property (wr_at(out_route_pkg::ADDR_LL_LEVEL) |=>
        (left_line_out_unmute == $past(reg_wdata[3])))
        else $error("left line mute write not applied");

    chk_ro_keep: assert property (wr_at(out_route_pkg::ADDR_LL_LEVEL)
        ##[1:3] rd_at(out_route_pkg::ADDR_LL_LEVEL) |=>
        (reg_rdata[2] == 1'b0) && (reg_rdata[0] == $past(pwr_sync)))
        else $error("write disturbed read-only status bits");

    chk_ro_rsvd_write: assert property (wr_at(out_route_pkg::ADDR_RSVD_B)
        ##[1:3] rd_at(out_route_pkg::ADDR_RSVD_B) |=> (reg_rdata == 8'h02))
        else $error("write to read-only reserved location took effect");

    chk_pwr_sync: assert property ($rose(left_line_out_powered_pin) && !srst
        ##1 left_line_out_powered_pin [*2] |-> pwr_sync)
        else $error("power status pin not seen after two flops");

endmodule // output_driver_routing_regs
`default_nettype wire

// File: sim/line_power_model.sv
// analog side of the left line driver: reports full power after a ramp
// assumes the power request is driven off the falling edge of sys_clk
`timescale 1ns/100ps
`default_nettype none
module line_power_model #(
    parameter int RAMP = 10
) (
    // clock
    input  wire logic sys_clk,
    // power request in, status pin out
    input  wire logic power_req,
    output logic      powered_pin
);
    int count = 0;
    // dropping the request drops the status at the next rising edge, like a supply collapse
    always @(posedge sys_clk) begin
        if (!power_req)
            count <= 0;
        else if (count < RAMP)
            count <= count + 1;
    end
    assign powered_pin = (count == RAMP);
endmodule // line_power_model
`default_nettype wire

// File: sim/tb_output_driver_routing_regs.sv
// self-checking bench for the output driver routing register bank
// assumes byte strobes on reg_wr/reg_rd, inputs changed at falling edges
`timescale 1ns/100ps
`default_nettype none
module tb_output_driver_routing_regs;
    logic            sys_clk   = 1'b0;
    logic            srst      = 1'b1;
    logic [7:0]      reg_addr  = 8'h00;
    logic            reg_wr    = 1'b0;
    logic [7:0]      reg_wdata = 8'h00;
    logic            reg_rd    = 1'b0;
    logic [7:0]      reg_rdata;
    logic            reg_rvalid;
    logic            power_req = 1'b0;
    logic            pin;
    logic            rhp_en, rc_en, rc_unmute, rc_hiz, rc_pwr, ll_unmute;
    logic [6:0]      rhp_vol, rc_vol;
    logic [3:0]      rc_level, ll_en, ll_level;
    logic [3:0][6:0] ll_vol;
    logic [7:0]      got;
    logic [7:0]      vals [6] = '{8'hFF, 8'h85, 8'h7F, 8'h80, 8'h01, 8'hAA};
    int              err_count = 0;
    int              n_tests   = 0;
    int              cycles    = 0;

    line_power_model #(.RAMP(10)) lp (.sys_clk(sys_clk), .power_req(power_req),
        .powered_pin(pin));
    output_driver_routing_regs uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .left_line_out_powered_pin(pin),
        .right_headphone_out_src_en(rhp_en), .right_headphone_out_vol(rhp_vol),
        .right_common_headphone_out_src_en(rc_en), .right_common_headphone_out_vol(rc_vol),
        .right_common_headphone_out_level(rc_level),
        .right_common_headphone_out_unmute(rc_unmute),
        .right_common_headphone_out_pd_hiz(rc_hiz),
        .right_common_headphone_out_power_up(rc_pwr), .left_line_out_src_en(ll_en),
        .left_line_out_vol(ll_vol), .left_line_out_level(ll_level),
        .left_line_out_unmute(ll_unmute));

    always #4 sys_clk = ~sys_clk;

    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // whole run needs about 600 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
        n_tests++;
        if (act !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    // strobe is taken at the rising edge; answer stands for the next cycle only
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check_byte({7'h00, reg_rvalid}, 8'h01);
        check_byte(reg_rdata, exp);
    endtask

    function automatic logic [7:0] reset_value(input logic [7:0] a);
        case (a)
            8'h48:        return 8'h06;
            8'h4F, 8'h56: return 8'h02;
            default:      return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] src_out(input int i);
        if (i == 0)
            return {rhp_en, rhp_vol};
        if (i == 1)
            return {rc_en, rc_vol};
        return {ll_en[i-2], ll_vol[i-2]};
    endfunction

    initial begin
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        check_byte({rc_en, rc_unmute, rc_hiz, rc_pwr, ll_unmute, 3'h0}, 8'h20);
        for (int i = 0; i < 18; i++) begin
            got = (i == 0) ? 8'h40 : 8'(8'h46 + i);
            read_check(got, reset_value(got));
        end
        for (int i = 0; i < 6; i++) begin
            reg_write(out_route_pkg::SRC_ADDR[i], vals[i]);
            check_byte(src_out(i), vals[i]);
            read_check(out_route_pkg::SRC_ADDR[i], vals[i]);
        end
        repeat (130) @(negedge sys_clk);
        read_check(8'h48, 8'h04);
        read_check(8'h56, 8'h00);
        // legal level codes only, each a change so the settle count restarts
        for (int c = 9; c >= 0; c--) begin
            reg_write(8'h48, {4'(c), 4'hD});
            @(negedge sys_clk);
            got = {rc_level, rc_unmute, rc_hiz, 1'b0, rc_pwr};
            check_byte(got, {4'(c), 4'hD});
            read_check(8'h48, {4'(c), 4'hF});
        end
        repeat (130) @(negedge sys_clk);
        reg_write(8'h48, 8'h02);
        check_byte({rc_unmute, rc_hiz, rc_pwr, 5'h00}, 8'h00);
        read_check(8'h48, 8'h00);
        power_req = 1'b1;
        repeat (20) @(negedge sys_clk);
        reg_write(8'h56, 8'h5F);
        @(negedge sys_clk);
        check_byte({ll_level, ll_unmute, 3'h0}, 8'h58);
        read_check(8'h56, 8'h5B);
        repeat (130) @(negedge sys_clk);
        read_check(8'h56, 8'h59);
        power_req = 1'b0;
        repeat (10) @(negedge sys_clk);
        read_check(8'h56, 8'h58);
        for (int a = 8'h49; a <= 8'h50; a++) begin
            reg_write(8'(a), 8'hFF);
            read_check(8'(a), reset_value(8'(a)));
        end
        // write and read in one cycle: the read returns the old contents
        @(negedge sys_clk);
        reg_addr  = 8'h53;
        reg_wdata = 8'hA5;
        reg_wr    = 1'b1;
        reg_rd    = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        check_byte(reg_rdata, 8'h00);
        read_check(8'h53, 8'hA5);
        reg_write(8'h57, 8'h3C);
        read_check(8'h57, 8'h3C);
        reg_write(8'h60, 8'hFF);
        read_check(8'h60, 8'h00);
        print_verdict();
    end
endmodule // tb_output_driver_routing_regs
`default_nettype wire
